//--- src/sgm_defines.vh
/*
 * Constants for the sensor pin output multiplexer: register indices and address
 * shift, field positions, reset value, pin modes and source codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SGM_DEFINES_VH
`define SGM_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------------------
`define SGM_IDX_PIN_MODE_AND_PAD_CTRL  12'h022
`define SGM_IDX_PIN01_SOURCE_SELECT    12'h023
`define SGM_IDX_PIN23_SOURCE_SELECT    12'h024
`define SGM_IDX_PIN_INPUT_READBACK     12'h025
`define SGM_IDX_PIN_EXTENDED_CTRL      12'h026
`define SGM_IDX_STAMP_ARM_CTRL         12'h027
`define SGM_ADDR_W                     12
`define SGM_ADDR_SHIFT                 2

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define SGM_SLEW_HI          15
`define SGM_SLEW_LO          14
`define SGM_DRV_HI           13
`define SGM_DRV_LO           12
`define SGM_MODE_W           3
`define SGM_SRC_W            7
`define SGM_SRC_LO_FIELD     6:0
`define SGM_SRC_HI_FIELD     14:8
`define SGM_SRC_MASK         16'h7F7F
`define SGM_EXT_MASK         16'h01F0
`define SGM_EXT_IDLE_BIT     8
`define SGM_EXT_INV_BIT      7
`define SGM_EXT_ALWAYS_BIT   6
`define SGM_EXT_PIN_HI       5
`define SGM_EXT_PIN_LO       4
`define SGM_ARM_BIT          0
`define SGM_RESET_VALUE      16'h0000

// ----------------------------------------------------------------------------
// Pin modes
// ----------------------------------------------------------------------------
`define SGM_MODE_OFF         3'h0
`define SGM_MODE_INPUT       3'h1
`define SGM_MODE_OUT_HI      1'h0
`define SGM_MODE_OUT_TAG     2'h1
`define SGM_MODE_PULL_TAG    1'h1

// ----------------------------------------------------------------------------
// Source codes
// ----------------------------------------------------------------------------
`define SGM_SRC_LOW          7'h00
`define SGM_SRC_HIGH         7'h01
`define SGM_SRC_IRQ_X        7'h02
`define SGM_SRC_IRQ_Y        7'h03
`define SGM_SRC_ANY_LED_AMP  7'h0C
`define SGM_SRC_OSC_DIV64    7'h0F
`define SGM_SRC_SLOT_PATTERN 7'h10
`define SGM_SRC_SLEEP        7'h11
`define SGM_SRC_OSC_LF       7'h16
`define SGM_SRC_OSC_32M      7'h17
`define SGM_SRC_OSC_DIV32    7'h18
`define SGM_LED_AMP_PREFIX   5'h02
`define SGM_GRP_ACTIVE       3'h2
`define SGM_GRP_LED_PULSE    3'h3
`define SGM_GRP_MOD_PULSE    3'h4
`define SGM_GRP_DATA_CYCLE   3'h5
`define SGM_LAST_SLOT        4'hB
`define SGM_ANY_SLOT         4'hF
`define SGM_SLOTS            12

`endif

//--- src/sgm_pin_mux.v
/*
 * Four-pin general-purpose output multiplexer with pad control, input
 * readback and timestamp trigger, reached over APB.
 * Assumes slot, interrupt, LED and sleep signals come from logic on pclk;
 * oscillator outputs and pin levels are asynchronous and are synchronised.
 */
// The implementer's own choice: register access over APB.
// Operation
// - Three-bit mode per pin sets pad behaviour
// - Shared slew and drive settings reach pads
// - Seven-bit source selector per pin, shared table
// - Codes 0-3: low, high, two interrupts
// - Codes 08-0B LED amp enables, 0C any
// - Codes 0F,16,17,18 route oscillator clocks
// - Pattern code: idle level after slot, sleep
// - Code 11 high while device sleeps
// - Codes 20-2B: slot active indications
// - Codes 30-3B slot LED pulse, 3F any
// - Codes 40-4B modulation pulse, 4F any
// - Codes 50-5B data cycle, 5F any
// - Readback shows sampled level of input pins
// - Trigger edge rising, falling when inverted
// - Always-armed keeps arm bit after capture
// - Two-bit field selects trigger pin, default 0
// - Pattern code: high during flagged slots
// - Arm bit captures next edge, then clears
`timescale 1ns/1ns
`include "sgm_defines.vh"

module sgm_pin_mux (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        irq_x,
    input  wire        irq_y,
    input  wire [3:0]  led_amp_en,
    input  wire        osc_div64,
    input  wire        osc_lf,
    input  wire        osc_32m,
    input  wire        osc_div32,
    input  wire        sleep_state,
    input  wire [11:0] slot_active,
    input  wire [11:0] slot_led_pulse,
    input  wire [11:0] slot_mod_pulse,
    input  wire [11:0] slot_data_cycle,
    input  wire [11:0] slot_pin_flag,
    input  wire [3:0]  pin_in,
    output reg  [3:0]  pin_out,
    output reg  [3:0]  pin_oe,
    output reg  [3:0]  pin_in_en,
    output reg  [3:0]  pin_pull_up,
    output reg  [3:0]  pin_pull_down,
    output reg  [1:0]  pad_slew_setting,
    output reg  [1:0]  pad_drive_setting,
    output reg         stamp_capture
);

// ----------------------------------------------------------------------------
// Registers and synchronisers
// ----------------------------------------------------------------------------
reg  [15:0] pin_mode_and_pad_ctrl;
reg  [15:0] pin01_source_select;
reg  [15:0] pin23_source_select;
reg  [15:0] pin_extended_ctrl;
reg         stamp_arm;
reg  [3:0]  pin_in_meta;
reg  [3:0]  pin_in_sync;
reg  [3:0]  osc_meta;
reg  [3:0]  osc_sync;
reg  [3:0]  pin_input_readback;
reg         trig_prev;

wire [`SGM_ADDR_W-1:0] word_idx = paddr[`SGM_ADDR_W+`SGM_ADDR_SHIFT-1:`SGM_ADDR_SHIFT];
wire        addr_ok = (paddr[`SGM_ADDR_SHIFT-1:0] == 2'h0) &&
                      (paddr[31:`SGM_ADDR_W+`SGM_ADDR_SHIFT] == 18'h00000);
wire        acc     = psel & penable & pready;
wire        wr      = acc & pwrite;

wire [2:0]  mode [0:3];
wire [6:0]  src_sel [0:3];
assign mode[0]    = pin_mode_and_pad_ctrl[2:0];
assign mode[1]    = pin_mode_and_pad_ctrl[5:3];
assign mode[2]    = pin_mode_and_pad_ctrl[8:6];
assign mode[3]    = pin_mode_and_pad_ctrl[11:9];
assign src_sel[0] = pin01_source_select[`SGM_SRC_LO_FIELD];
assign src_sel[1] = pin01_source_select[`SGM_SRC_HI_FIELD];
assign src_sel[2] = pin23_source_select[`SGM_SRC_LO_FIELD];
assign src_sel[3] = pin23_source_select[`SGM_SRC_HI_FIELD];

// ----------------------------------------------------------------------------
// APB slave: one wait state, registered answer
// ----------------------------------------------------------------------------
reg  [31:0] next_prdata;
reg         next_err;
always @* begin
    next_prdata = 32'h00000000;
    next_err    = 1'b0;
    if (!addr_ok) begin
        next_err = 1'b1;
    end else if (word_idx == `SGM_IDX_PIN_MODE_AND_PAD_CTRL) begin
        next_prdata = {16'h0000, pin_mode_and_pad_ctrl};
    end else if (word_idx == `SGM_IDX_PIN01_SOURCE_SELECT) begin
        next_prdata = {16'h0000, pin01_source_select};
    end else if (word_idx == `SGM_IDX_PIN23_SOURCE_SELECT) begin
        next_prdata = {16'h0000, pin23_source_select};
    end else if (word_idx == `SGM_IDX_PIN_INPUT_READBACK) begin
        next_prdata = {28'h0000000, pin_input_readback};
    end else if (word_idx == `SGM_IDX_PIN_EXTENDED_CTRL) begin
        next_prdata = {16'h0000, pin_extended_ctrl};
    end else if (word_idx == `SGM_IDX_STAMP_ARM_CTRL) begin
        next_prdata = {31'h00000000, stamp_arm};
    end else begin
        next_err = 1'b1;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready  <= 1'b0;
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
    end else begin
        pready <= psel & penable & ~pready;
        if (psel & penable & ~pready) begin
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= next_err;
        end else begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------------
// Writable registers
// ----------------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_mode_and_pad_ctrl <= `SGM_RESET_VALUE;
        pin01_source_select   <= `SGM_RESET_VALUE;
        pin23_source_select   <= `SGM_RESET_VALUE;
        pin_extended_ctrl     <= `SGM_RESET_VALUE;
    end else if (wr && addr_ok) begin
        if (word_idx == `SGM_IDX_PIN_MODE_AND_PAD_CTRL) begin
            pin_mode_and_pad_ctrl <= pwdata[15:0];
        end else if (word_idx == `SGM_IDX_PIN01_SOURCE_SELECT) begin
            pin01_source_select <= pwdata[15:0] & `SGM_SRC_MASK;
        end else if (word_idx == `SGM_IDX_PIN23_SOURCE_SELECT) begin
            pin23_source_select <= pwdata[15:0] & `SGM_SRC_MASK;
        end else if (word_idx == `SGM_IDX_PIN_EXTENDED_CTRL) begin
            pin_extended_ctrl <= pwdata[15:0] & `SGM_EXT_MASK;
        end
    end
end

// ----------------------------------------------------------------------------
// Synchronisers for pin levels and oscillator outputs
// ----------------------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_in_meta <= 4'h0;
        pin_in_sync <= 4'h0;
        osc_meta    <= 4'h0;
        osc_sync    <= 4'h0;
    end else begin
        pin_in_meta <= pin_in;
        pin_in_sync <= pin_in_meta;
        osc_meta    <= {osc_div32, osc_32m, osc_lf, osc_div64};
        osc_sync    <= osc_meta;
    end
end

// ----------------------------------------------------------------------------
// Source selection and pad control per pin
// ----------------------------------------------------------------------------
wire pattern_level = (~sleep_state & |(slot_active & slot_pin_flag)) ?
                     1'b1 : pin_extended_ctrl[`SGM_EXT_IDLE_BIT];

reg  [3:0] src_val;
reg  [3:0] next_out;
reg  [3:0] next_oe;
reg  [3:0] next_ie;
reg  [3:0] next_pu;
reg  [3:0] next_pd;

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_pin
        always @* begin
            src_val[g] = 1'b0;
            case (src_sel[g])
                `SGM_SRC_LOW:          src_val[g] = 1'b0;
                `SGM_SRC_HIGH:         src_val[g] = 1'b1;
                `SGM_SRC_IRQ_X:        src_val[g] = irq_x;
                `SGM_SRC_IRQ_Y:        src_val[g] = irq_y;
                `SGM_SRC_ANY_LED_AMP:  src_val[g] = |led_amp_en;
                `SGM_SRC_OSC_DIV64:    src_val[g] = osc_sync[0];
                `SGM_SRC_SLOT_PATTERN: src_val[g] = pattern_level;
                `SGM_SRC_SLEEP:        src_val[g] = sleep_state;
                `SGM_SRC_OSC_LF:       src_val[g] = osc_sync[1];
                `SGM_SRC_OSC_32M:      src_val[g] = osc_sync[2];
                `SGM_SRC_OSC_DIV32:    src_val[g] = osc_sync[3];
                default: begin
                    if (src_sel[g][6:2] == `SGM_LED_AMP_PREFIX) begin
                        src_val[g] = led_amp_en[src_sel[g][1:0]];
                    end else if (src_sel[g][3:0] <= `SGM_LAST_SLOT) begin
                        case (src_sel[g][6:4])
                            `SGM_GRP_ACTIVE:     src_val[g] = slot_active[src_sel[g][3:0]];
                            `SGM_GRP_LED_PULSE:  src_val[g] = slot_led_pulse[src_sel[g][3:0]];
                            `SGM_GRP_MOD_PULSE:  src_val[g] = slot_mod_pulse[src_sel[g][3:0]];
                            `SGM_GRP_DATA_CYCLE: src_val[g] = slot_data_cycle[src_sel[g][3:0]];
                            default:             src_val[g] = 1'b0;
                        endcase
                    end else if (src_sel[g][3:0] == `SGM_ANY_SLOT) begin
                        case (src_sel[g][6:4])
                            `SGM_GRP_LED_PULSE:  src_val[g] = |slot_led_pulse;
                            `SGM_GRP_MOD_PULSE:  src_val[g] = |slot_mod_pulse;
                            `SGM_GRP_DATA_CYCLE: src_val[g] = |slot_data_cycle;
                            default:             src_val[g] = 1'b0;
                        endcase
                    end
                end
            endcase
        end

        // Inversion is applied to the selected source before the pad
        always @* begin
            next_out[g] = 1'b0;
            next_oe[g]  = 1'b0;
            next_ie[g]  = 1'b0;
            next_pu[g]  = 1'b0;
            next_pd[g]  = 1'b0;
            if (mode[g] == `SGM_MODE_INPUT) begin
                next_ie[g] = 1'b1;
            end else if (mode[g][2:1] == `SGM_MODE_OUT_TAG) begin
                next_oe[g]  = 1'b1;
                next_out[g] = src_val[g] ^ mode[g][0];
            end else if (mode[g][2] == `SGM_MODE_PULL_TAG) begin
                if (mode[g][1] == `SGM_MODE_OUT_HI) begin
                    next_pd[g] = ~(src_val[g] ^ mode[g][0]);
                end else begin
                    next_pu[g] = src_val[g] ^ mode[g][0];
                end
            end
        end
    end
endgenerate

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_out           <= 4'h0;
        pin_oe            <= 4'h0;
        pin_in_en         <= 4'h0;
        pin_pull_up       <= 4'h0;
        pin_pull_down     <= 4'h0;
        pad_slew_setting  <= 2'h0;
        pad_drive_setting <= 2'h0;
    end else begin
        pin_out           <= next_out;
        pin_oe            <= next_oe;
        pin_in_en         <= next_ie;
        pin_pull_up       <= next_pu;
        pin_pull_down     <= next_pd;
        pad_slew_setting  <= pin_mode_and_pad_ctrl[`SGM_SLEW_HI:`SGM_SLEW_LO];
        pad_drive_setting <= pin_mode_and_pad_ctrl[`SGM_DRV_HI:`SGM_DRV_LO];
    end
end

// ----------------------------------------------------------------------------
// Input readback and timestamp trigger
// ----------------------------------------------------------------------------
wire [3:0] in_enabled;
generate
    for (g = 0; g < 4; g = g + 1) begin : g_ie
        assign in_enabled[g] = (mode[g] == `SGM_MODE_INPUT);
    end
endgenerate

wire [1:0] trig_pin = pin_extended_ctrl[`SGM_EXT_PIN_HI:`SGM_EXT_PIN_LO];
wire trig_level = pin_in_sync[trig_pin] ^ pin_extended_ctrl[`SGM_EXT_INV_BIT];
wire trig_edge  = trig_level & ~trig_prev;
wire capture    = stamp_arm & trig_edge;
wire arm_write  = wr && addr_ok && (word_idx == `SGM_IDX_STAMP_ARM_CTRL);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_input_readback <= 4'h0;
        trig_prev          <= 1'b0;
        stamp_arm          <= 1'b0;
        stamp_capture      <= 1'b0;
    end else begin
        pin_input_readback <= pin_in_sync & in_enabled;
        trig_prev          <= trig_level;
        stamp_capture      <= capture;
        if (arm_write && pwdata[`SGM_ARM_BIT]) begin
            stamp_arm <= 1'b1;
        end else if (arm_write) begin
            stamp_arm <= 1'b0;
        end else if (capture && !pin_extended_ctrl[`SGM_EXT_ALWAYS_BIT]) begin
            stamp_arm <= 1'b0;
        end
    end
end

endmodule // sgm_pin_mux

//--- bench/sgm_pin_mux_assertions.sv
/*
 * Port checker for sgm_pin_mux, bound to every instance of it.
 * Assumes one clock domain and registers at byte address four times the index.
 */
`timescale 1ns/1ns
module sgm_pin_mux_assertions (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [3:0]  pin_oe,
    input wire [3:0]  pin_pull_up,
    input wire [3:0]  pin_pull_down,
    input wire [1:0]  pad_slew_setting,
    input wire [1:0]  pad_drive_setting,
    input wire        stamp_capture
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside answer");
    a_err_misalign: assert property (pready && psel && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access without pslverr");
    a_pad_copy: assert property (psel && penable && pready && pwrite && paddr == 32'h88
        |=> ##1 pad_slew_setting == $past(pwdata[15:14], 2)
        && pad_drive_setting == $past(pwdata[13:12], 2))
        else $error("pad settings differ from written value");
    a_pull_no_drive: assert property ((pin_oe & (pin_pull_up | pin_pull_down)) == 4'h0)
        else $error("pull active on a driven pin");
    a_pull_exclusive: assert property ((pin_pull_up & pin_pull_down) == 4'h0)
        else $error("pull-up and pull-down together");
    a_reset_quiet: assert property ($rose(presetn) |-> pin_oe == 4'h0 && pready == 1'b0
        && stamp_capture == 1'b0 && pin_pull_up == 4'h0)
        else $error("outputs active at reset release");
    a_stamp_single: assert property (stamp_capture |=> !stamp_capture)
        else $error("capture strobe longer than one cycle");
endmodule // sgm_pin_mux_assertions

bind sgm_pin_mux sgm_pin_mux_assertions i_sgm_pin_mux_assertions (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_oe, .pin_pull_up,
    .pin_pull_down, .pad_slew_setting, .pad_drive_setting, .stamp_capture);

//--- bench/sgm_pad_partner.sv
/*
 * Far side of the four pads: external drivers, pull resistors, floating level.
 * Assumes the bench owns ext_en and ext_val and never drives a driven pad.
 */
`timescale 1ns/1ns
module sgm_pad_partner (
    input  wire        pclk,
    input  wire [3:0]  pin_out,
    input  wire [3:0]  pin_oe,
    input  wire [3:0]  pin_pull_up,
    input  wire [3:0]  pin_pull_down,
    input  wire [3:0]  ext_en,
    input  wire [3:0]  ext_val,
    output logic [3:0] pin_in
);
    // A floating pad toggles so a stale level is never read as valid
    logic [3:0] float_lvl = 4'h5;

    always @(posedge pclk) float_lvl <= ~float_lvl;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pull_up[i]) pin_in[i] = 1'b1;
            else if (pin_pull_down[i]) pin_in[i] = 1'b0;
            else pin_in[i] = float_lvl[i];
        end
    end
endmodule // sgm_pad_partner

//--- bench/tb_top.sv
/*
 * Self-checking bench for sgm_pin_mux: APB master, source table, pulls, trigger.
 * Assumes sgm_defines.vh, the pad partner and the bound checker.
 */
`timescale 1ns/1ns
`include "sgm_defines.vh"
module tb_top;
    typedef struct packed {logic rd; logic [31:0] d; logic [31:0] m; logic er;} sgm_note_t;
    localparam [31:0] addr_mode = 4 * `SGM_IDX_PIN_MODE_AND_PAD_CTRL;
    localparam [31:0] addr_01   = 4 * `SGM_IDX_PIN01_SOURCE_SELECT;
    localparam [31:0] addr_23   = 4 * `SGM_IDX_PIN23_SOURCE_SELECT;
    localparam [31:0] addr_in   = 4 * `SGM_IDX_PIN_INPUT_READBACK;
    localparam [31:0] addr_ext  = 4 * `SGM_IDX_PIN_EXTENDED_CTRL;
    localparam [31:0] addr_arm  = 4 * `SGM_IDX_STAMP_ARM_CTRL;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0;
    logic        irq_x = 1'b0, irq_y = 1'b0, osc_div64 = 1'b0, osc_lf = 1'b0;
    logic        osc_32m = 1'b0, osc_div32 = 1'b0, sleep_state = 1'b0;
    logic [3:0]  led_amp_en = 4'h0, ext_en = 4'h0, ext_val = 4'h0;
    logic [11:0] slot_active = 12'h0, slot_led_pulse = 12'h0, slot_mod_pulse = 12'h0;
    logic [11:0] slot_data_cycle = 12'h0, slot_pin_flag = 12'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, stamp_capture;
    wire  [3:0]  pin_in, pin_out, pin_oe, pin_in_en, pin_pull_up, pin_pull_down;
    wire  [1:0]  pad_slew_setting, pad_drive_setting;
    int          seed = 62, mismatches = 0, cmp_count = 0, stamp_seen = 0;
    sgm_note_t   notes[$];
    sgm_note_t   cur;

    sgm_pin_mux i_sgm_pin_mux (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq_x, .irq_y, .led_amp_en, .osc_div64, .osc_lf,
        .osc_32m, .osc_div32, .sleep_state, .slot_active, .slot_led_pulse, .slot_mod_pulse,
        .slot_data_cycle, .slot_pin_flag, .pin_in, .pin_out, .pin_oe, .pin_in_en,
        .pin_pull_up, .pin_pull_down, .pad_slew_setting, .pad_drive_setting, .stamp_capture);
    sgm_pad_partner i_sgm_pad_partner (.pclk, .pin_out, .pin_oe, .pin_pull_up,
        .pin_pull_down, .ext_en, .ext_val, .pin_in);

    initial begin
        forever #2 pclk = ~pclk;
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic [31:0] m, input logic er);
        int n;
        notes.push_back({!w, e, m, er});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 32'hFFFFFFFF, 1'b0);
    endtask

    task automatic rnd_src();
        logic [31:0] r0, r1, r2;
        r0 = $random(seed);
        r1 = $random(seed);
        r2 = $random(seed);
        {irq_x, irq_y, led_amp_en, osc_div64, osc_lf, osc_32m, osc_div32, sleep_state} <= r0[10:0];
        slot_pin_flag <= r0[22:11];
        {slot_active, slot_led_pulse} <= r1[23:0];
        {slot_mod_pulse, slot_data_cycle} <= r2[23:0];
    endtask

    task automatic pin_edge(input int k, input logic lvl);
        ext_val[k] <= lvl;
        repeat (8) @(posedge pclk);
    endtask

    // Expected pin level for a source code; idle level is set to 0 by the bench
    function automatic logic ref_src(input logic [6:0] c);
        if (c >= 7'h20 && c <= 7'h5F && c[3:0] <= 4'hB) begin
            case (c[6:4])
                3'h2: return slot_active[c[3:0]];
                3'h3: return slot_led_pulse[c[3:0]];
                3'h4: return slot_mod_pulse[c[3:0]];
                default: return slot_data_cycle[c[3:0]];
            endcase
        end
        case (c)
            7'h01: return 1'b1;
            7'h02: return irq_x;
            7'h03: return irq_y;
            7'h08, 7'h09, 7'h0A, 7'h0B: return led_amp_en[c[1:0]];
            7'h0C: return |led_amp_en;
            7'h0F: return osc_div64;
            7'h10: return (|(slot_active & slot_pin_flag) && !sleep_state) ? 1'b1 : 1'b0;
            7'h11: return sleep_state;
            7'h16: return osc_lf;
            7'h17: return osc_32m;
            7'h18: return osc_div32;
            7'h3F: return |slot_led_pulse;
            7'h4F: return |slot_mod_pulse;
            7'h5F: return |slot_data_cycle;
            default: return 1'b0;
        endcase
    endfunction

    always @(posedge pclk) begin
        if (stamp_capture === 1'b1) stamp_seen++;
        if (pready === 1'b1) begin
            cur = notes.pop_front();
            chk({31'h0, pslverr}, {31'h0, cur.er});
            if (cur.rd) chk(prdata & cur.m, cur.d);
        end
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [6:0]  c;
        logic        e, inv;
        int          base;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd(addr_mode + 32'(4 * i), 32'h0);
        apb(1'b0, 32'hFC, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
        apb(1'b1, addr_mode + 32'h1, 32'hFFFF, 32'h0, 32'h0, 1'b1);
        rd(addr_mode, 32'h0);
        r = $random(seed);
        wr(addr_mode, {16'h0, r[15:0]});
        rd(addr_mode, {16'h0, r[15:0]});
        chk({30'h0, pad_slew_setting}, {30'h0, r[15:14]});
        chk({30'h0, pad_drive_setting}, {30'h0, r[13:12]});
        wr(addr_in, 32'hFFFF);
        apb(1'b0, addr_in, 32'h0, 32'h0, 32'hFFF0, 1'b0);
        wr(addr_01, 32'hFFFF);
        rd(addr_01, 32'h7F7F);
        wr(addr_ext, 32'hFFFF);
        rd(addr_ext, 32'h01F0);
        wr(addr_mode, 32'h69A);
        wr(addr_ext, 32'h000);
        for (int i = 0; i < 96; i++) begin
            c = i[6:0];
            rnd_src();
            wr(addr_01, {17'h0, c, 1'b0, c});
            wr(addr_23, {17'h0, c, 1'b0, c});
            repeat (4) @(posedge pclk);
            e = ref_src(c);
            chk({28'h0, pin_out}, {28'h0, ~e, e, ~e, e});
            chk({28'h0, pin_oe}, 32'hF);
        end
        wr(addr_mode, 32'h66);
        ext_en <= 4'h4;
        for (int i = 0; i < 2; i++) begin
            inv = i[0];
            ext_val <= {1'b0, inv, 2'h0};
            wr(addr_01, inv ? 32'h101 : 32'h0);
            wr(addr_23, inv ? 32'h101 : 32'h0);
            repeat (4) @(posedge pclk);
            chk({31'h0, pin_pull_up[0]}, {31'h0, inv});
            chk({31'h0, pin_pull_down[1]}, {31'h0, ~inv});
            chk({28'h0, pin_oe}, 32'h0);
            chk({30'h0, pin_in_en[3:2]}, 32'h1);
            apb(1'b0, addr_in, 32'h0, {29'h0, inv, 2'h0}, 32'h4, 1'b0);
        end
        wr(addr_mode, 32'h249);
        ext_en <= 4'hF;
        for (int k = 0; k < 4; k++) begin
            inv = k[0];
            ext_val <= {4{~inv}};
            wr(addr_ext, {24'h0, inv, 1'b0, 2'(k), 4'h0});
            base = stamp_seen;
            wr(addr_arm, 32'h1);
            rd(addr_arm, 32'h1);
            pin_edge((k + 1) % 4, inv);
            pin_edge((k + 1) % 4, ~inv);
            pin_edge(k, inv);
            chk(stamp_seen - base, 32'h0);
            pin_edge(k, ~inv);
            chk(stamp_seen - base, 32'h1);
            rd(addr_arm, 32'h0);
        end
        wr(addr_ext, 32'h40);
        base = stamp_seen;
        wr(addr_arm, 32'h1);
        pin_edge(0, 1'b1);
        pin_edge(0, 1'b0);
        pin_edge(0, 1'b1);
        chk(stamp_seen - base, 32'h2);
        rd(addr_arm, 32'h1);
        report_and_stop();
    end
endmodule // tb_top
